// ===== rtl/nicd_pkg.sv
// Purpose: constants for the host-side nand init and command sequencer
// Assumes: ref_clk at 100 MHz; nand pins decoded combinationally from flip-flop state
// Notes:   opcodes, command kinds and timing counts live here
package nicd_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_RESET     = 8'hFF;
    localparam logic [7:0] OP_READ_ID   = 8'h90;
    localparam logic [7:0] OP_PARAM     = 8'hEC;
    localparam logic [7:0] OP_UID       = 8'hED;
    localparam logic [7:0] OP_GET_FEAT  = 8'hEE;
    localparam logic [7:0] OP_SET_FEAT  = 8'hEF;
    localparam logic [7:0] OP_STATUS    = 8'h70;
    localparam logic [7:0] OP_STATUS_EN = 8'h78;
    localparam logic [7:0] OP_RND_READ  = 8'h05;
    localparam logic [7:0] OP_RND_CONF  = 8'hE0;
    localparam logic [7:0] OP_RND_INPUT = 8'h85;
    localparam logic [7:0] OP_READ      = 8'h00;
    localparam logic [7:0] OP_READ_CONF = 8'h30;
    localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
    localparam logic [7:0] OP_CACHE_END = 8'h3F;
    localparam logic [7:0] OP_PROG      = 8'h80;
    localparam logic [7:0] OP_PROG_CONF = 8'h10;
    localparam logic [7:0] OP_NONE      = 8'h00;

    // status bit that mirrors the ready flag of the unit
    localparam int STAT_RDY_BIT = 6;

    // ----------------------------------------------------------------
    // command kinds the user may request
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        NICD_CMD_RESET      = 4'h0,
        NICD_CMD_READ_ID    = 4'h1,
        NICD_CMD_PARAM      = 4'h2,
        NICD_CMD_UID        = 4'h3,
        NICD_CMD_GET_FEAT   = 4'h4,
        NICD_CMD_SET_FEAT   = 4'h5,
        NICD_CMD_STATUS     = 4'h6,
        NICD_CMD_STATUS_EN  = 4'h7,
        NICD_CMD_RND_READ   = 4'h8,
        NICD_CMD_RND_INPUT  = 4'h9,
        NICD_CMD_READ_PAGE  = 4'hA,
        NICD_CMD_PROG_PAGE  = 4'hB,
        NICD_CMD_CACHE_RND  = 4'hC,
        NICD_CMD_CACHE_SEQ  = 4'hD,
        NICD_CMD_CACHE_END  = 4'hE,
        NICD_CMD_NOP        = 4'hF
    } nicd_cmd_type;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int T_RB_VALID_US  = 50;   // from start of supply ramp
    localparam int T_NO_RB_US     = 100;  // wait when ready/busy is not watched
    localparam int T_RST_BUSY_US  = 1000; // reset busy, 1 ms
    localparam int RB_VALID_CYC   = T_RB_VALID_US * CLK_MHZ;
    localparam int NO_RB_CYC      = T_NO_RB_US * CLK_MHZ;
    localparam int RST_BUSY_CYC   = T_RST_BUSY_US * CLK_MHZ;
    // cycles of each strobe phase, low and high; 30 ns write cycle fits in two
    localparam int STROBE_PH_CYC  = 2;

endpackage

// ===== rtl/nicd_timer.sv
// Purpose: down-counting wait timer used by the sequencer
// Assumes: load and count share the one clock
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module nicd_timer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    // state
    output logic                  done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == '0);
endmodule

// ===== rtl/nicd_host.sv
// Purpose: host controller: power-on init, first reset and command sequencing
// Assumes: supply ramp start coincides with release of sys_rst; ready/busy
//          arrives synchronous to ref_clk, high when ready
// Notes:   one byte per strobe cycle; data bytes come from the user one at a time
`timescale 1ns/1ps
module nicd_host
    import nicd_pkg::*;
#(
    parameter int RB_VALID_CYCLES = RB_VALID_CYC,
    parameter int NO_RB_CYCLES    = NO_RB_CYC,
    parameter int RST_BUSY_CYCLES = RST_BUSY_CYC,
    parameter int SET_FEAT_BYTES  = 4
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    // strategy: poll ready/busy pin when high, except in the timed first reset wait; else poll status byte
    input  wire logic                use_rb_pin,
    // user request
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire nicd_pkg::nicd_cmd_type req_cmd,
    input  wire logic [39:0]         req_addr,
    input  wire logic [7:0]          req_data,
    output logic                     data_take,
    input  wire logic [7:0]          data_count,
    output logic                     init_done,
    output logic                     busy_reject,
    // nand pins
    output logic                     chip_en_n,
    output logic                     cmd_latch,
    output logic                     addr_latch,
    output logic                     write_strobe_n,
    output logic                     read_strobe_n,
    output logic                     write_prot_n,
    output logic [7:0]               io_out,
    output logic                     io_oe,
    input  wire logic [7:0]          io_in,
    input  wire logic                ready_busy
);
    import nicd_pkg::*;

    typedef enum logic [3:0] {
        NICD_S_POWER   = 4'h0,
        NICD_S_IDLE    = 4'h1,
        NICD_S_CMD1    = 4'h2,
        NICD_S_ADDR    = 4'h3,
        NICD_S_DATA    = 4'h4,
        NICD_S_CMD2    = 4'h5,
        NICD_S_WAIT    = 4'h6,
        NICD_S_POLLCMD = 4'h7,
        NICD_S_POLLRD  = 4'h8
    } nicd_state_type;

    // ----------------------------------------------------------------
    // decode of a command kind into its bus shape
    // ----------------------------------------------------------------
    function automatic logic [7:0] op1_of(nicd_cmd_type c);
        case (c)
            NICD_CMD_RESET:     op1_of = OP_RESET;
            NICD_CMD_READ_ID:   op1_of = OP_READ_ID;
            NICD_CMD_PARAM:     op1_of = OP_PARAM;
            NICD_CMD_UID:       op1_of = OP_UID;
            NICD_CMD_GET_FEAT:  op1_of = OP_GET_FEAT;
            NICD_CMD_SET_FEAT:  op1_of = OP_SET_FEAT;
            NICD_CMD_STATUS:    op1_of = OP_STATUS;
            NICD_CMD_STATUS_EN: op1_of = OP_STATUS_EN;
            NICD_CMD_RND_READ:  op1_of = OP_RND_READ;
            NICD_CMD_RND_INPUT: op1_of = OP_RND_INPUT;
            NICD_CMD_PROG_PAGE: op1_of = OP_PROG;
            NICD_CMD_CACHE_SEQ: op1_of = OP_CACHE_SEQ;
            NICD_CMD_CACHE_END: op1_of = OP_CACHE_END;
            default:            op1_of = OP_READ;
        endcase
    endfunction

    function automatic logic [2:0] naddr_of(nicd_cmd_type c);
        case (c)
            NICD_CMD_READ_ID, NICD_CMD_PARAM, NICD_CMD_UID,
            NICD_CMD_GET_FEAT, NICD_CMD_SET_FEAT: naddr_of = 3'h1;
            NICD_CMD_STATUS_EN:                   naddr_of = 3'h3;
            NICD_CMD_RND_READ, NICD_CMD_RND_INPUT: naddr_of = 3'h2;
            NICD_CMD_READ_PAGE, NICD_CMD_PROG_PAGE,
            NICD_CMD_CACHE_RND:                   naddr_of = 3'h5;
            default:                              naddr_of = 3'h0;
        endcase
    endfunction

    function automatic logic [7:0] op2_of(nicd_cmd_type c);
        case (c)
            NICD_CMD_RND_READ:  op2_of = OP_RND_CONF;
            NICD_CMD_READ_PAGE: op2_of = OP_READ_CONF;
            NICD_CMD_PROG_PAGE: op2_of = OP_PROG_CONF;
            NICD_CMD_CACHE_RND: op2_of = OP_CACHE_SEQ;
            default:            op2_of = OP_NONE;
        endcase
    endfunction

    function automatic logic has_op2(nicd_cmd_type c);
        has_op2 = (c == NICD_CMD_RND_READ) || (c == NICD_CMD_READ_PAGE) ||
                  (c == NICD_CMD_PROG_PAGE) || (c == NICD_CMD_CACHE_RND);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    nicd_state_type state, next_state;
    nicd_cmd_type   cmd, next_cmd;
    logic [39:0]    addr, next_addr;
    logic [2:0]     acnt, next_acnt;
    logic [7:0]     dcnt, next_dcnt;
    logic [1:0]     ph, next_ph;       // strobe phase counter
    logic           strobe_lo, next_strobe_lo;
    logic           first_done, next_first_done;
    logic           init, next_init;
    logic           reject, next_reject;
    logic [7:0]     obyte, next_obyte;
    logic           pow_armed, next_pow_armed;
    logic [23:0]    pow_age, next_pow_age;     // cycles spent in the power wait
    logic           stat_rdy, next_stat_rdy;   // ready bit of the last status byte
    logic           t_load;
    logic [23:0]    t_value;
    logic           t_done;
    logic           strobe_end;

    nicd_timer #(.WIDTH(24)) u_timer (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .load       (t_load),
        .load_value (t_value),
        .done       (t_done)
    );

    // a strobe cycle ends when the high phase has run its length
    assign strobe_end = !strobe_lo && (ph == 2'(STROBE_PH_CYC - 1));

    always_comb begin
        next_state      = state;
        next_cmd        = cmd;
        next_addr       = addr;
        next_acnt       = acnt;
        next_dcnt       = dcnt;
        next_first_done = first_done;
        next_init       = init;
        next_reject     = 1'b0;
        next_obyte      = obyte;
        next_stat_rdy   = stat_rdy;
        next_ph         = (ph == 2'(STROBE_PH_CYC - 1)) ? 2'h0 : ph + 2'h1;
        next_strobe_lo  = (ph == 2'(STROBE_PH_CYC - 1)) ? !strobe_lo : strobe_lo;
        t_load          = 1'b0;
        t_value         = '0;
        case (state)
            NICD_S_POWER: begin
                // wait loaded once after reset, pin-valid or blind length
                if (!pow_armed) begin
                    t_load  = 1'b1;
                    t_value = 24'(use_rb_pin ? RB_VALID_CYCLES : NO_RB_CYCLES);
                end else if (t_done && (!use_rb_pin || ready_busy)) begin
                    next_cmd   = NICD_CMD_RESET;
                    next_state = NICD_S_CMD1;
                    next_ph    = 2'h0;
                    next_strobe_lo = 1'b1;
                end
            end
            NICD_S_IDLE: begin
                next_ph = 2'h0;
                next_strobe_lo = 1'b1;
                if (req_valid) begin
                    // a busy target takes only reset and status
                    if (!ready_busy && req_cmd != NICD_CMD_RESET &&
                        req_cmd != NICD_CMD_STATUS && req_cmd != NICD_CMD_STATUS_EN) begin
                        next_reject = 1'b1;
                    end else if (req_cmd != NICD_CMD_NOP) begin
                        next_cmd   = req_cmd;
                        next_addr  = req_addr;
                        next_dcnt  = (req_cmd == NICD_CMD_SET_FEAT) ?
                                     8'(SET_FEAT_BYTES) : data_count;
                        next_state = NICD_S_CMD1;
                    end
                end
            end
            NICD_S_CMD1: begin
                next_obyte = op1_of(cmd);
                if (strobe_end) begin
                    next_acnt = naddr_of(cmd);
                    if (cmd == NICD_CMD_RESET) begin
                        next_first_done = 1'b1;
                        t_load = 1'b1;
                        t_value = 24'(RST_BUSY_CYCLES);
                        next_state = NICD_S_WAIT;
                    end else if (naddr_of(cmd) != 3'h0) begin
                        next_state = NICD_S_ADDR;
                    end else begin
                        next_state = NICD_S_IDLE;
                    end
                end
            end
            NICD_S_ADDR: begin
                next_obyte = addr[7:0];
                if (strobe_end) begin
                    next_addr = {8'h00, addr[39:8]};
                    next_acnt = acnt - 3'h1;
                    if (acnt == 3'h1) begin
                        if ((cmd == NICD_CMD_SET_FEAT || cmd == NICD_CMD_PROG_PAGE ||
                             cmd == NICD_CMD_RND_INPUT) && dcnt != 8'h00)
                            next_state = NICD_S_DATA;
                        else if (has_op2(cmd))
                            next_state = NICD_S_CMD2;
                        else
                            next_state = NICD_S_IDLE;
                    end
                end
            end
            NICD_S_DATA: begin
                next_obyte = req_data;
                if (strobe_end) begin
                    next_dcnt = dcnt - 8'h01;
                    if (dcnt == 8'h01)
                        next_state = has_op2(cmd) ? NICD_S_CMD2 : NICD_S_IDLE;
                end
            end
            NICD_S_CMD2: begin
                next_obyte = op2_of(cmd);
                if (strobe_end)
                    next_state = NICD_S_IDLE;
            end
            NICD_S_WAIT: begin
                // the timer bounds the wait; once init is set, the ready/busy pin may end it early
                next_ph = 2'h0;
                next_strobe_lo = 1'b1;
                if (t_done || (use_rb_pin && ready_busy && ph == 2'h0 && init))
                    next_state = use_rb_pin ? NICD_S_IDLE : NICD_S_POLLCMD;
                if (t_done && use_rb_pin)
                    next_init = 1'b1;
            end
            NICD_S_POLLCMD: begin
                next_obyte = OP_STATUS;
                if (strobe_end)
                    next_state = NICD_S_POLLRD;
            end
            NICD_S_POLLRD: begin
                // take the byte while the read strobe is low; the bus is released after
                if (strobe_lo && ph == 2'(STROBE_PH_CYC - 1))
                    next_stat_rdy = io_in[STAT_RDY_BIT];
                if (strobe_end) begin
                    if (stat_rdy) begin
                        next_init  = 1'b1;
                        next_state = NICD_S_IDLE;
                    end else begin
                        next_state = NICD_S_POLLCMD;
                    end
                end
            end
            default: next_state = NICD_S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state      <= NICD_S_POWER;
            cmd        <= NICD_CMD_NOP;
            addr       <= '0;
            acnt       <= 3'h0;
            dcnt       <= 8'h00;
            ph         <= 2'h0;
            strobe_lo  <= 1'b1;
            first_done <= 1'b0;
            init       <= 1'b0;
            reject     <= 1'b0;
            obyte      <= 8'h00;
            stat_rdy   <= 1'b0;
        end else begin
            state      <= next_state;
            cmd        <= next_cmd;
            addr       <= next_addr;
            acnt       <= next_acnt;
            dcnt       <= next_dcnt;
            ph         <= next_ph;
            strobe_lo  <= next_strobe_lo;
            first_done <= next_first_done;
            init       <= next_init;
            reject     <= next_reject;
            obyte      <= next_obyte;
            stat_rdy   <= next_stat_rdy;
        end
    end

    // power-on wait: load once in the cycle after reset
    always_comb begin
        next_pow_armed = 1'b1;
        next_pow_age   = pow_age;
        if (state == NICD_S_POWER && pow_age != '1)
            next_pow_age = pow_age + 24'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pow_armed <= 1'b0;
            pow_age   <= '0;
        end else begin
            pow_armed <= next_pow_armed;
            pow_age   <= next_pow_age;
        end
    end

    // ----------------------------------------------------------------
    // pins; asynchronous mode is default, nothing selects it
    // ----------------------------------------------------------------
    logic active;
    assign active         = (state == NICD_S_CMD1) || (state == NICD_S_ADDR) ||
                            (state == NICD_S_DATA) || (state == NICD_S_CMD2) ||
                            (state == NICD_S_POLLCMD) || (state == NICD_S_POLLRD);
    assign chip_en_n      = !active;
    assign cmd_latch      = (state == NICD_S_CMD1) || (state == NICD_S_CMD2) ||
                            (state == NICD_S_POLLCMD);
    assign addr_latch     = (state == NICD_S_ADDR);
    assign write_strobe_n = !(active && state != NICD_S_POLLRD && strobe_lo);
    assign read_strobe_n  = !(state == NICD_S_POLLRD && strobe_lo);
    assign write_prot_n   = init;   // hold write protect until init completes
    assign io_out         = obyte;
    assign io_oe          = active && (state != NICD_S_POLLRD);
    assign req_ready      = (state == NICD_S_IDLE);
    assign data_take      = (state == NICD_S_DATA) && strobe_end;
    assign init_done      = init;
    assign busy_reject    = reject;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_reset_byte;
        cmd_latch && io_out == OP_RESET && !write_strobe_n;
    endsequence

    a_reset_after_rb: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_POWER && next_state == NICD_S_CMD1) |-> (!use_rb_pin || ready_busy))
        else $error("reset issued before ready/busy high");
    a_power_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_POWER && next_state == NICD_S_CMD1) |->
        (pow_age > 24'(use_rb_pin ? RB_VALID_CYCLES : NO_RB_CYCLES)))
        else $error("first command before power wait");
    a_first_is_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!first_done && active) |-> (cmd == NICD_CMD_RESET))
        else $error("first command is not reset");
    a_reset_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_CMD1 && cmd == NICD_CMD_RESET && strobe_end) |=>
        (state == NICD_S_WAIT && !t_done))
        else $error("reset busy wait not started");
    a_poll_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_POLLRD && strobe_end && !stat_rdy) |=>
        (state == NICD_S_POLLCMD))
        else $error("status poll not repeated");
    a_cache_confirm: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_CMD2 && cmd == NICD_CMD_CACHE_RND) |=> (io_out == OP_CACHE_SEQ))
        else $error("cache read confirm wrong");
    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_IDLE && req_valid && !ready_busy &&
         (req_cmd == NICD_CMD_CACHE_RND || req_cmd == NICD_CMD_READ_ID)) |=>
        (busy_reject && state == NICD_S_IDLE))
        else $error("command sent to busy target");
    a_single_op: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == NICD_S_CMD1 && strobe_end &&
         (cmd == NICD_CMD_CACHE_END || cmd == NICD_CMD_CACHE_SEQ)) |=> (state == NICD_S_IDLE))
        else $error("single opcode command took addresses");
    a_latch_excl: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !write_strobe_n |-> (!chip_en_n && read_strobe_n && !(cmd_latch && addr_latch)))
        else $error("write strobe with bad latch levels");
endmodule

// ===== bench/nicd_dev_model.sv
// Purpose: behavioural nand target answering the host sequencer
// Assumes: one target with one unit; waits scaled down, in ns
// Notes:   each written byte is logged as {cmd_latch, addr_latch, byte}
`timescale 1ns/1ps
module nicd_dev_model #(
    parameter int PWR_NS = 300,
    parameter int RST_NS = 500
) (
    // host pins
    input  wire logic       chip_en_n,
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_prot_n,
    input  wire logic [7:0] io_out,
    output logic      [7:0] io_in,
    output logic            ready_busy,
    // bench control
    input  wire logic       hold_busy
);
    logic [9:0] log_q[$];
    logic       rdy = 1'b0;
    logic       bad_cmd = 1'b0;
    logic [7:0] last_cmd = 8'h00;
    logic [7:0] last_io = 8'h00;
    logic [7:0] stat;
    assign ready_busy = rdy && !hold_busy;
    assign stat = {write_prot_n, ready_busy, 6'h20};
    // released bus shows the inverse of its last value, never a stale copy
    assign io_in = (!chip_en_n && !read_strobe_n) ? stat : ~last_io;
    initial #PWR_NS rdy = 1'b1;
    always @(posedge read_strobe_n) last_io = stat;
    always @(posedge write_strobe_n) begin
        if (!chip_en_n && read_strobe_n) begin
            last_io = io_out;
            log_q.push_back({cmd_latch, addr_latch, io_out});
            if (cmd_latch && !addr_latch) begin
                if (ready_busy || io_out == 8'h70 || io_out == 8'h78)
                    last_cmd = io_out;
                else
                    bad_cmd = 1'b1;
                if (io_out == 8'hFF) begin
                    rdy = 1'b0;
                    rdy <= #RST_NS 1'b1;
                end
            end
        end
    end
endmodule

// ===== bench/nand_init_command_decode_test.sv
// Purpose: self-checking bench for the nand init and command sequencer
// Assumes: shortened wait parameters; target model on the pins
// Notes:   bytes seen on the pins are compared with expected sequences
`timescale 1ns/1ps
module nand_init_command_decode_test;
    import nicd_pkg::*;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         use_rb_pin = 1'b0;
    logic         req_valid = 1'b0;
    logic         hold_busy = 1'b0;
    nicd_cmd_type req_cmd = NICD_CMD_NOP;
    logic [39:0]  req_addr = 40'hA1B2C3D4E5;
    logic [7:0]   req_data = 8'h5A;
    logic [7:0]   data_count = 8'h02;
    logic         req_ready, data_take, init_done, busy_reject, write_prot_n, io_oe;
    logic         chip_en_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
    logic         ready_busy;
    logic [7:0]   io_out, io_in;
    int           error_cnt = 0;
    int           n_checks = 0;
    int           n_take = 0;
    int           n_oe_bad = 0;
    // command, opcode, addresses, data bytes, confirm flag, confirm opcode
    logic [31:0]  tab [14] = '{32'h19010000, 32'h2EC10000, 32'h3ED10000, 32'h4EE10000,
        32'h5EF14000, 32'h67000000, 32'h77830000, 32'h805201E0, 32'h98522000,
        32'hA0050130, 32'hB8052110, 32'hC0050131, 32'hD3100000, 32'hE3F00000};

    nicd_host #(.RB_VALID_CYCLES(20), .NO_RB_CYCLES(40), .RST_BUSY_CYCLES(50)) dut_u (
        .ref_clk, .sys_rst, .use_rb_pin, .req_valid, .req_ready, .req_cmd, .req_addr,
        .req_data, .data_take, .data_count, .init_done, .busy_reject, .chip_en_n,
        .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n, .write_prot_n,
        .io_out, .io_oe, .io_in, .ready_busy);
    nicd_dev_model dev_u (.chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
        .read_strobe_n, .write_prot_n, .io_out, .io_in, .ready_busy, .hold_busy);

    initial forever #5 ref_clk = ~ref_clk;

    // data strobes and bus direction watched mid-cycle, where they are settled
    always @(negedge ref_clk) begin
        if (data_take === 1'b1) n_take++;
        if ((!write_strobe_n && io_oe !== 1'b1) || (!read_strobe_n && io_oe !== 1'b0))
            n_oe_bad++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // request held until taken; refusal looked for in the cycles after
    task automatic send(input nicd_cmd_type c, input logic rej);
        int n = 0;
        logic seen = 1'b0;
        @(negedge ref_clk);
        req_cmd = c;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        repeat (3) begin
            seen = seen | (busy_reject === 1'b1);
            @(negedge ref_clk);
        end
        check(16'(seen), 16'(rej));
        while (req_ready !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        if (req_ready !== 1'b1) error_cnt++;
    endtask

    task automatic expect_log(input logic [7:0] op, input logic [3:0] na,
                              input logic [3:0] nd, input logic [8:0] cf);
        logic [9:0] e[$];
        e.push_back({2'b10, op});
        for (int i = 0; i < na; i++) e.push_back({2'b01, req_addr[8*i +: 8]});
        for (int i = 0; i < nd; i++) e.push_back({2'b00, req_data});
        if (cf[8]) e.push_back({2'b10, cf[7:0]});
        check(16'(dev_u.log_q.size()), 16'(e.size()));
        foreach (e[i]) check(16'(dev_u.log_q[i]), 16'(e[i]));
    endtask

    task automatic t_init;
        int n = 0;
        while (chip_en_n !== 1'b0 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(n > 40), 16'h0001);
        while (init_done !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(init_done), 16'h0001);
        check(16'(dev_u.log_q[0]), 16'h02FF);
        check(16'(dev_u.log_q[1]), 16'h0270);
        check(16'(dev_u.bad_cmd), 16'h0000);
        check(16'(write_prot_n), 16'h0001);
    endtask

    task automatic t_table;
        use_rb_pin = 1'b1;
        foreach (tab[i]) begin
            dev_u.log_q.delete();
            n_take = 0;
            send(nicd_cmd_type'(tab[i][31:28]), 1'b0);
            expect_log(tab[i][27:20], tab[i][19:16], tab[i][15:12], tab[i][8:0]);
            check(16'(n_take), 16'(tab[i][15:12]));
        end
    endtask

    task automatic t_busy;
        hold_busy = 1'b1;
        dev_u.log_q.delete();
        send(NICD_CMD_CACHE_RND, 1'b1);
        send(NICD_CMD_READ_ID, 1'b1);
        check(16'(dev_u.log_q.size()), 16'h0000);
        send(NICD_CMD_STATUS, 1'b0);
        expect_log(8'h70, 4'h0, 4'h0, 9'h000);
        hold_busy = 1'b0;
        check(16'(n_oe_bad), 16'h0000);
    endtask

    initial begin
        #100000;
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_init;
        t_table;
        t_busy;
        tally_and_finish;
    end
endmodule
